// ==== hw/mdc_debounce.sv ====
/*
 Two-flop synchroniser and debounce filter for one push button.
 Assumes the raw input is asynchronous to ref_clk and may bounce.
*/
`timescale 1ns/1ps
`default_nettype none
module mdc_debounce #(
   parameter int unsigned DEB_CYCLES = mdc_pkg::DEB_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Button
   input wire logic raw_in,
   output logic level_r
);
   logic sync1_r;
   logic sync2_r;
   logic [31:0] cnt_r;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
      end
   end

   // Level changes only after the new value has been stable the whole window
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= 32'h0000_0000;
         level_r <= 1'b0;
      end else if (sync2_r == level_r) begin
         cnt_r <= 32'h0000_0000;
      end else if (cnt_r >= DEB_CYCLES - 1) begin
         cnt_r <= 32'h0000_0000;
         level_r <= sync2_r;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end
endmodule : mdc_debounce
`default_nettype wire

// ==== hw/mdc_meter_ctrl.sv ====
/*
 Display and mode control of the combination instrument: view cycling,
 clock setting, unit toggle, speed scaling, odometer and trip meters,
 ignition gating of display and needles.
 Assumes buttons, ignition, fuel-flash and speed sensor arrive from pins,
 and that odometer retention is held by external non-volatile storage
 that presents the saved count on odo_nv_value at reset release.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Mode press cycles clock, odometer, trips
// - Flashing fuel gauge adds fuel view
// - Long reset in clock view starts setting
// - Reset in combined set selects hour set
// - Mode press in hour set advances hour
// - Reset moves to minute set; mode advances
// - Reset in minute set returns to combined
// - Mode in combined set resumes, seconds restart
// - Reset with mode held in odometer view toggles units
// - Pulse frequency scaled to speed reading
// - Odometer accumulates, restored after power loss
// - Odometer locks at its maximum
// - Trips accumulate; long reset clears shown
// - No ignition keeps display blank, needles idle
// - Ignition drives needles, segments and lamps
module mdc_meter_ctrl
   import mdc_pkg::*;
#(
   parameter int unsigned DEB_CYCLES = mdc_pkg::DEB_CYCLES,
   parameter int unsigned HOLD_CYCLES = mdc_pkg::HOLD_CYCLES,
   parameter int unsigned SEC_CYCLES = mdc_pkg::SEC_CYCLES,
   parameter int unsigned WIN_MPH_CYCLES = mdc_pkg::WIN_MPH_CYCLES,
   parameter int unsigned WIN_KMH_CYCLES = mdc_pkg::WIN_KMH_CYCLES
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Pins from the vehicle
   input wire logic mode_btn,
   input wire logic reset_btn,
   input wire logic ignition_in,
   input wire logic fuel_flash_in,
   input wire logic speed_pulse_in,
   // Saved odometer from non-volatile store
   input wire logic [mdc_pkg::ODO_W-1:0] odo_nv_value,
   // Display content
   output mdc_pkg::mdc_view_e view_r,
   output logic [4:0] hour_r,
   output logic [5:0] minute_r,
   output logic flash_hour_r,
   output logic flash_min_r,
   output logic unit_km_r,
   output logic [mdc_pkg::SPEED_W-1:0] speed_r,
   output logic [mdc_pkg::ODO_W-1:0] odo_r,
   output logic [mdc_pkg::TRIP_W-1:0] trip_a_r,
   output logic [mdc_pkg::TRIP_W-1:0] trip_b_r,
   // Ignition gating
   output logic display_on_r,
   output logic lamps_on_r,
   output logic needles_on_r
);
   import mdc_pkg::*;

   function automatic logic at_last(input logic [31:0] cnt, input int unsigned lim);
      at_last = (cnt >= 32'(lim - 1));
   endfunction : at_last

   logic mode_lvl;
   logic reset_lvl;
   logic mode_prev_r;
   logic reset_prev_r;
   logic mode_rise;
   logic mode_fall;
   logic reset_rise;
   logic chord_r;
   logic mode_click;
   logic [31:0] hold_cnt_r;
   logic long_hold;
   logic [1:0] ign_sync_r;
   logic [1:0] fuel_sync_r;
   logic [2:0] spd_sync_r;
   logic spd_edge;
   mdc_set_e set_r;
   logic [31:0] sec_cnt_r;
   logic [5:0] second_r;
   logic [31:0] win_cnt_r;
   logic [SPEED_W-1:0] pulse_cnt_r;
   logic [15:0] tenth_cnt_r;
   logic tenth_evt;
   logic [3:0] odo_frac_r;
   logic restored_r;

   mdc_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb_mode (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .raw_in(mode_btn),
      .level_r(mode_lvl)
   );

   mdc_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb_reset (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .raw_in(reset_btn),
      .level_r(reset_lvl)
   );

   // Pin synchronisers; the first stage feeds only the second
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ign_sync_r <= 2'h0;
         fuel_sync_r <= 2'h0;
         spd_sync_r <= 3'h0;
      end else begin
         ign_sync_r <= {ign_sync_r[0], ignition_in};
         fuel_sync_r <= {fuel_sync_r[0], fuel_flash_in};
         spd_sync_r <= {spd_sync_r[1:0], speed_pulse_in};
      end
   end
   assign spd_edge = spd_sync_r[1] & ~spd_sync_r[2];

   // Button events
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         mode_prev_r <= 1'b0;
         reset_prev_r <= 1'b0;
      end else begin
         mode_prev_r <= mode_lvl;
         reset_prev_r <= reset_lvl;
      end
   end
   assign mode_rise = mode_lvl & ~mode_prev_r;
   assign mode_fall = ~mode_lvl & mode_prev_r;
   assign reset_rise = reset_lvl & ~reset_prev_r;

   // View advances on release; a chord or the press that ends setting must not step it
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         chord_r <= 1'b0;
      end else if (mode_rise) begin
         chord_r <= (set_r != SET_NONE);
      end else if (reset_rise && mode_lvl) begin
         chord_r <= 1'b1;
      end
   end
   assign mode_click = mode_fall & ~chord_r & (set_r == SET_NONE);

   // Hold timer fires once when reset alone has been held for the hold time
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         hold_cnt_r <= 32'h0000_0000;
      end else if (!reset_lvl) begin
         hold_cnt_r <= 32'h0000_0000;
      end else if (!at_last(hold_cnt_r, HOLD_CYCLES + 1)) begin
         hold_cnt_r <= hold_cnt_r + 32'h0000_0001;
      end
   end
   assign long_hold = reset_lvl & ~mode_lvl & (hold_cnt_r == 32'(HOLD_CYCLES - 1));

   // View cycling
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         view_r <= VIEW_CLOCK;
      end else if (mode_click) begin
         case (view_r)
            VIEW_CLOCK: view_r <= fuel_sync_r[1] ? VIEW_FUEL : VIEW_ODO;
            VIEW_FUEL: view_r <= VIEW_ODO;
            VIEW_ODO: view_r <= VIEW_TRIP_A;
            VIEW_TRIP_A: view_r <= VIEW_TRIP_B;
            VIEW_TRIP_B: view_r <= VIEW_CLOCK;
            default: view_r <= VIEW_CLOCK;
         endcase
      end
   end

   // Clock-setting sequence
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         set_r <= SET_NONE;
      end else begin
         case (set_r)
            SET_NONE: if (long_hold && view_r == VIEW_CLOCK) set_r <= SET_BOTH;
            SET_BOTH: begin
               if (reset_rise) begin
                  set_r <= SET_HOUR;
               end else if (mode_rise) begin
                  set_r <= SET_NONE;
               end
            end
            SET_HOUR: if (reset_rise) set_r <= SET_MIN;
            SET_MIN: if (reset_rise) set_r <= SET_BOTH;
            default: set_r <= SET_NONE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         flash_hour_r <= 1'b0;
         flash_min_r <= 1'b0;
      end else begin
         flash_hour_r <= (set_r == SET_BOTH) || (set_r == SET_HOUR);
         flash_min_r <= (set_r == SET_BOTH) || (set_r == SET_MIN);
      end
   end

   // Time of day; counting halts while setting
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sec_cnt_r <= 32'h0000_0000;
         second_r <= SECOND_RST;
         minute_r <= MINUTE_RST;
         hour_r <= HOUR_RST;
      end else begin
         case (set_r)
            SET_BOTH: begin
               if (mode_rise && !reset_rise) begin
                  sec_cnt_r <= 32'h0000_0000;
                  second_r <= SECOND_RST;
               end
            end
            SET_HOUR: begin
               if (mode_rise) hour_r <= (hour_r == HOUR_MAX) ? HOUR_RST : hour_r + 5'h01;
            end
            SET_MIN: begin
               if (mode_rise) begin
                  minute_r <= (minute_r == MINUTE_MAX) ? MINUTE_RST : minute_r + 6'h01;
               end
            end
            default: begin
               if (!at_last(sec_cnt_r, SEC_CYCLES)) begin
                  sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
               end else begin
                  sec_cnt_r <= 32'h0000_0000;
                  if (second_r != MINUTE_MAX) begin
                     second_r <= second_r + 6'h01;
                  end else begin
                     second_r <= SECOND_RST;
                     if (minute_r != MINUTE_MAX) begin
                        minute_r <= minute_r + 6'h01;
                     end else begin
                        minute_r <= MINUTE_RST;
                        hour_r <= (hour_r == HOUR_MAX) ? HOUR_RST : hour_r + 5'h01;
                     end
                  end
               end
            end
         endcase
      end
   end

   // Unit toggle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         unit_km_r <= UNIT_KM_RST;
      end else if (view_r == VIEW_ODO && reset_rise && mode_lvl && set_r == SET_NONE) begin
         unit_km_r <= ~unit_km_r;
      end
   end

   // Speed: pulses counted over a gate window sized so the count is the reading
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         win_cnt_r <= 32'h0000_0000;
         pulse_cnt_r <= '0;
         speed_r <= '0;
      end else if (at_last(win_cnt_r, unit_km_r ? WIN_KMH_CYCLES : WIN_MPH_CYCLES)) begin
         win_cnt_r <= 32'h0000_0000;
         pulse_cnt_r <= '0;
         speed_r <= pulse_cnt_r;
      end else begin
         win_cnt_r <= win_cnt_r + 32'h0000_0001;
         if (spd_edge && pulse_cnt_r != SPEED_SAT) pulse_cnt_r <= pulse_cnt_r + 8'h01;
      end
   end

   // Distance prescaler, in tenths of the current unit
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tenth_cnt_r <= 16'h0000;
      end else if (spd_edge) begin
         tenth_cnt_r <= tenth_evt ? 16'h0000 : tenth_cnt_r + 16'h0001;
      end
   end
   assign tenth_evt = spd_edge &&
      (tenth_cnt_r >= (unit_km_r ? KMH_PULSE_TENTH : MPH_PULSE_TENTH) - 16'h0001);

   // Odometer, reloaded from the store on the first edge after reset release
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         restored_r <= 1'b0;
         odo_r <= '0;
         odo_frac_r <= 4'h0;
      end else if (!restored_r) begin
         restored_r <= 1'b1;
         odo_r <= (odo_nv_value > ODO_MAX) ? ODO_MAX : odo_nv_value;
      end else if (tenth_evt && odo_r != ODO_MAX) begin
         if (odo_frac_r == TENTHS_MAX) begin
            odo_frac_r <= 4'h0;
            odo_r <= odo_r + 20'h0_0001;
         end else begin
            odo_frac_r <= odo_frac_r + 4'h1;
         end
      end
   end

   // Trip meters; a clear wins over a coincident increment
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         trip_a_r <= '0;
         trip_b_r <= '0;
      end else begin
         if (long_hold && view_r == VIEW_TRIP_A) begin
            trip_a_r <= '0;
         end else if (tenth_evt) begin
            trip_a_r <= (trip_a_r == TRIP_MAX) ? '0 : trip_a_r + 17'h0_0001;
         end
         if (long_hold && view_r == VIEW_TRIP_B) begin
            trip_b_r <= '0;
         end else if (tenth_evt) begin
            trip_b_r <= (trip_b_r == TRIP_MAX) ? '0 : trip_b_r + 17'h0_0001;
         end
      end
   end

   // Ignition gating; everything stays dark until ignition is seen
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         display_on_r <= 1'b0;
         lamps_on_r <= 1'b0;
         needles_on_r <= 1'b0;
      end else begin
         display_on_r <= ign_sync_r[1];
         lamps_on_r <= ign_sync_r[1];
         needles_on_r <= ign_sync_r[1];
      end
   end
endmodule : mdc_meter_ctrl
`default_nettype wire

// ==== hw/mdc_pkg.sv ====
/*
 Constants, timing counts and state encodings shared by the instrument
 display and mode-control block and its input conditioner.
 Assumes a single 100 MHz reference clock.
*/
package mdc_pkg;
   localparam longint CLK_HZ = 100_000_000;
   // Button timing
   localparam int HOLD_TIME_MS = 2000;
   localparam int DEB_TIME_MS = 10;
   localparam int unsigned HOLD_CYCLES = 32'(CLK_HZ * HOLD_TIME_MS / 1000);
   localparam int unsigned DEB_CYCLES = 32'(CLK_HZ * DEB_TIME_MS / 1000);
   localparam int unsigned SEC_CYCLES = 32'(CLK_HZ);
   // Speed scaling: reference frequency in tenths of Hz reads REF_SPEED
   localparam longint MPH_REF_HZ_X10 = 1690;
   localparam longint KMH_REF_HZ_X10 = 1056;
   localparam longint REF_SPEED = 60;
   localparam int unsigned WIN_MPH_CYCLES = 32'(CLK_HZ * REF_SPEED * 10 / MPH_REF_HZ_X10);
   localparam int unsigned WIN_KMH_CYCLES = 32'(CLK_HZ * REF_SPEED * 10 / KMH_REF_HZ_X10);
   // Sensor pulses per 0.1 distance unit, rounded to nearest
   localparam logic [15:0] MPH_PULSE_TENTH = 16'((MPH_REF_HZ_X10 * 6 + 5) / 10);
   localparam logic [15:0] KMH_PULSE_TENTH = 16'((KMH_REF_HZ_X10 * 6 + 5) / 10);
   // Widths and limits
   localparam int ODO_W = 20;
   localparam int TRIP_W = 17;
   localparam int SPEED_W = 8;
   localparam logic [ODO_W-1:0] ODO_MAX = 20'h0_F423F;
   localparam logic [TRIP_W-1:0] TRIP_MAX = 17'h1_869F;
   localparam logic [3:0] TENTHS_MAX = 4'h9;
   localparam logic [4:0] HOUR_MAX = 5'h17;
   localparam logic [5:0] MINUTE_MAX = 6'h3B;
   localparam logic [SPEED_W-1:0] SPEED_SAT = 8'hFF;
   // Reset values
   localparam logic [4:0] HOUR_RST = 5'h00;
   localparam logic [5:0] MINUTE_RST = 6'h00;
   localparam logic [5:0] SECOND_RST = 6'h00;
   localparam logic UNIT_KM_RST = 1'b0;

   typedef enum logic [2:0] {
      VIEW_CLOCK  = 3'b000,
      VIEW_FUEL   = 3'b001,
      VIEW_ODO    = 3'b010,
      VIEW_TRIP_A = 3'b011,
      VIEW_TRIP_B = 3'b100
   } mdc_view_e;

   typedef enum logic [1:0] {
      SET_NONE = 2'b00,
      SET_BOTH = 2'b01,
      SET_HOUR = 2'b10,
      SET_MIN  = 2'b11
   } mdc_set_e;
endpackage : mdc_pkg

// ==== tb/mdc_meter_properties.sv ====
/*
 Port assertions for the meter control block.
 Assumes it is bound onto mdc_meter_ctrl.
*/
`timescale 1ns/1ps
`default_nettype none
module mdc_meter_properties
   import mdc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Watched ports
   input wire logic ignition_in,
   input wire mdc_pkg::mdc_view_e view_r,
   input wire logic [4:0] hour_r,
   input wire logic [5:0] minute_r,
   input wire logic flash_hour_r,
   input wire logic flash_min_r,
   input wire logic [mdc_pkg::ODO_W-1:0] odo_r,
   input wire logic [mdc_pkg::TRIP_W-1:0] trip_a_r,
   input wire logic display_on_r,
   input wire logic lamps_on_r,
   input wire logic needles_on_r
);
   logic [1:0] up_r;
   // Edges since reset release; the ignition pipe is not valid before three
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         up_r <= 2'h0;
      end else if (up_r != 2'h3) begin
         up_r <= up_r + 2'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_hour_rise;
      !flash_hour_r ##1 flash_hour_r;
   endsequence
   // A wrap from the maximum is not a clear
   sequence s_trip_a_clear;
      trip_a_r != '0 && trip_a_r != TRIP_MAX ##1 trip_a_r == '0;
   endsequence
   a_ign_display: assert property (up_r == 2'h3 |-> display_on_r == $past(ignition_in, 3))
      else $error("display does not follow ignition");
   a_lamps_needles: assert property (lamps_on_r == display_on_r && needles_on_r == display_on_r)
      else $error("lamps or needles differ from display");
   a_odo_lock: assert property (odo_r == ODO_MAX |=> odo_r == ODO_MAX)
      else $error("odometer left its maximum");
   a_odo_step: assert property (up_r == 2'h3 && odo_r != $past(odo_r) |-> odo_r == $past(odo_r) + 20'h1)
      else $error("odometer moved by other than one");
   a_set_entry: assert property (s_hour_rise |-> flash_min_r && view_r == VIEW_CLOCK)
      else $error("set entry without both digits flashing");
   a_set_view_hold: assert property (flash_hour_r || flash_min_r |=> $stable(view_r))
      else $error("view moved during clock setting");
   a_time_range: assert property (hour_r <= HOUR_MAX && minute_r <= MINUTE_MAX)
      else $error("time value out of range");
   a_view_wrap: assert property ($changed(view_r) && $past(view_r) == VIEW_TRIP_B |-> view_r == VIEW_CLOCK)
      else $error("second trip view did not wrap to clock");
   a_view_order: assert property ($changed(view_r) && $past(view_r) == VIEW_ODO |-> view_r == VIEW_TRIP_A)
      else $error("odometer view not followed by first trip");
   a_clear_shown: assert property (s_trip_a_clear |-> view_r == VIEW_TRIP_A)
      else $error("first trip cleared while not shown");
endmodule : mdc_meter_properties
bind mdc_meter_ctrl mdc_meter_properties u_props (.ref_clk(ref_clk), .nrst(nrst),
   .ignition_in(ignition_in), .view_r(view_r), .hour_r(hour_r), .minute_r(minute_r),
   .flash_hour_r(flash_hour_r), .flash_min_r(flash_min_r), .odo_r(odo_r),
   .trip_a_r(trip_a_r), .display_on_r(display_on_r), .lamps_on_r(lamps_on_r),
   .needles_on_r(needles_on_r));
`default_nettype wire

// ==== tb/mdc_sensor_model.sv ====
/*
 Speed sensor model: square wave of four clock periods while run is high.
 Assumes the bench owns run; the line stands low between bursts.
*/
`timescale 1ns/1ps
`default_nettype none
module mdc_sensor_model (
   // Clock
   input wire logic ref_clk,
   // Control
   input wire logic run,
   // Sensor line
   output logic pulse
);
   logic [1:0] ph_r = 2'h0;
   // Phase moves on the falling edge, away from the sampling edge
   always_ff @(negedge ref_clk) begin
      ph_r <= ph_r + 2'h1;
   end
   assign pulse = run & ph_r[1];
endmodule : mdc_sensor_model
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
 Self-checking bench for the meter control block.
 Assumes shortened timing parameters and the sensor model on the speed line.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   import mdc_pkg::*;
   logic ref_clk, nrst, mode_btn, reset_btn, ignition_in, fuel_flash_in, run_pulse;
   wire logic speed_pulse_in;
   logic [ODO_W-1:0] odo_nv_value, odo_r;
   mdc_view_e view_r;
   logic [4:0] hour_r;
   logic [5:0] minute_r;
   logic flash_hour_r, flash_min_r, unit_km_r, display_on_r, lamps_on_r, needles_on_r;
   logic [SPEED_W-1:0] speed_r;
   logic [TRIP_W-1:0] trip_a_r, trip_b_r;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   mdc_meter_ctrl #(.DEB_CYCLES(4), .HOLD_CYCLES(50), .SEC_CYCLES(1000),
      .WIN_MPH_CYCLES(200), .WIN_KMH_CYCLES(300)) uut (.ref_clk(ref_clk), .nrst(nrst),
      .mode_btn(mode_btn), .reset_btn(reset_btn), .ignition_in(ignition_in),
      .fuel_flash_in(fuel_flash_in), .speed_pulse_in(speed_pulse_in),
      .odo_nv_value(odo_nv_value), .view_r(view_r), .hour_r(hour_r), .minute_r(minute_r),
      .flash_hour_r(flash_hour_r), .flash_min_r(flash_min_r), .unit_km_r(unit_km_r),
      .speed_r(speed_r), .odo_r(odo_r), .trip_a_r(trip_a_r), .trip_b_r(trip_b_r),
      .display_on_r(display_on_r), .lamps_on_r(lamps_on_r), .needles_on_r(needles_on_r));
   mdc_sensor_model u_sensor (.ref_clk(ref_clk), .run(run_pulse), .pulse(speed_pulse_in));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   // Long enough for debounce plus edge detect to settle after release
   task automatic press(input bit rst, input int hold);
      @(negedge ref_clk);
      if (rst) reset_btn = 1'b1; else mode_btn = 1'b1;
      repeat (hold) @(negedge ref_clk);
      if (rst) reset_btn = 1'b0; else mode_btn = 1'b0;
      repeat (16) @(negedge ref_clk);
   endtask : press
   task automatic t_ignition();
      repeat (10) @(negedge ref_clk);
      `CHK("display off", 1'b0, display_on_r)
      `CHK("needles off", 1'b0, needles_on_r)
      ignition_in = 1'b1;
      repeat (5) @(negedge ref_clk);
      `CHK("lamps on", 1'b1, lamps_on_r)
      `CHK("needles on", 1'b1, needles_on_r)
      ignition_in = 1'b0;
      repeat (5) @(negedge ref_clk);
      `CHK("display blank", 1'b0, display_on_r)
      ignition_in = 1'b1;
      $display("test ignition done");
   endtask : t_ignition
   task automatic t_views();
      mdc_view_e cyc_v[4] = '{VIEW_ODO, VIEW_TRIP_A, VIEW_TRIP_B, VIEW_CLOCK};
      foreach (cyc_v[i]) begin
         press(1'b0, 10);
         `CHK("view", cyc_v[i], view_r)
      end
      fuel_flash_in = 1'b1;
      press(1'b0, 10);
      `CHK("fuel view", VIEW_FUEL, view_r)
      press(1'b0, 10);
      `CHK("after fuel", VIEW_ODO, view_r)
      fuel_flash_in = 1'b0;
      repeat (3) press(1'b0, 10);
      `CHK("back to clock", VIEW_CLOCK, view_r)
      $display("test views done");
   endtask : t_views
   task automatic t_units();
      press(1'b0, 10);
      run_pulse = 1'b1;
      repeat (500) @(negedge ref_clk);
      `CHK("speed mph", 1'b1, speed_r >= 8'h31 && speed_r <= 8'h33)
      run_pulse = 1'b0;
      @(negedge ref_clk);
      mode_btn = 1'b1;
      repeat (12) @(negedge ref_clk);
      press(1'b1, 10);
      mode_btn = 1'b0;
      repeat (16) @(negedge ref_clk);
      `CHK("unit km", 1'b1, unit_km_r)
      `CHK("chord keeps view", VIEW_ODO, view_r)
      run_pulse = 1'b1;
      repeat (700) @(negedge ref_clk);
      `CHK("speed km", 1'b1, speed_r >= 8'h4A && speed_r <= 8'h4C)
      $display("test units done");
   endtask : t_units
   // About 7175 pulses at 634 a tenth give eleven tenths, crossing the lock
   task automatic t_odo_lock();
      repeat (28000) @(negedge ref_clk);
      run_pulse = 1'b0;
      repeat (20) @(negedge ref_clk);
      `CHK("odo locked", ODO_MAX, odo_r)
      `CHK("trip a tenths", 17'h0_000B, trip_a_r)
      `CHK("trip b tenths", 17'h0_000B, trip_b_r)
      $display("test odometer done");
   endtask : t_odo_lock
   task automatic t_trip_clear();
      press(1'b0, 10);
      `CHK("trip a view", VIEW_TRIP_A, view_r)
      press(1'b1, 70);
      `CHK("trip a cleared", 17'h0_0000, trip_a_r)
      `CHK("trip b kept", 17'h0_000B, trip_b_r)
      `CHK("odo kept", ODO_MAX, odo_r)
      $display("test trip clear done");
   endtask : t_trip_clear
   task automatic t_clock_set();
      repeat (2) press(1'b0, 10);
      press(1'b1, 70);
      `CHK("both flash", 2'h3, {flash_hour_r, flash_min_r})
      press(1'b1, 10);
      `CHK("hour flash", 2'h2, {flash_hour_r, flash_min_r})
      press(1'b0, 10);
      `CHK("hour up", 5'h01, hour_r)
      press(1'b1, 10);
      `CHK("min flash", 2'h1, {flash_hour_r, flash_min_r})
      press(1'b0, 10);
      `CHK("minute up", 6'h01, minute_r)
      press(1'b1, 10);
      `CHK("back to both", 2'h3, {flash_hour_r, flash_min_r})
      press(1'b0, 10);
      `CHK("set done", 2'h0, {flash_hour_r, flash_min_r})
      `CHK("time kept", 11'h041, {hour_r, minute_r})
      `CHK("view kept", VIEW_CLOCK, view_r)
      $display("test clock set done");
   endtask : t_clock_set
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      {nrst, mode_btn, reset_btn, ignition_in, fuel_flash_in, run_pulse} = 6'h00;
      odo_nv_value = 20'h0_F423E;
      repeat (10) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK("odo restored", 20'h0_F423E, odo_r)
      t_ignition();
      t_views();
      t_units();
      t_odo_lock();
      t_trip_clear();
      t_clock_set();
      summarize();
   end
endmodule : tb_top
`default_nettype wire
